/* shared/sst_consts.svh */
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SST_OFS_CONTROL_ONE   8'h00
`define SST_OFS_DATA_BUFFER   8'h04
`define SST_OFS_SERIAL_STATUS 8'h08
`define SST_OFS_BAUD_IDLE     8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SST_BIT_RUN           7
`define SST_BIT_ABORT         6
`define SST_BIT_MODE_HI       5
`define SST_BIT_MODE_LO       4
`define SST_BIT_SCK_HI        2
`define SST_BIT_SCK_LO        0
`define SST_BIT_ACTIVE        3
`define SST_BIT_SHIFT         2
`define SST_BIT_IDLE_RUN      6
`define SST_BIT_BAUD_ZERO     0

// ----------------------------------------------------------------
// Fixed read bits
// ----------------------------------------------------------------
`define SST_CTRL_ONES         32'h00000008
`define SST_STATUS_ONES       32'h000000F3
`define SST_BAUD_ONES         32'h000000BE

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define SST_MODE_TX           2'b00
`define SST_MODE_TXRX         2'b10
`define SST_MODE_RX           2'b11
`define SST_SCK_EXT           3'b111
`define SST_RST_MODE          2'b00
`define SST_RST_SCK           3'b000
`define SST_DUMMY_BYTE        8'hFF
`define SST_DIV_EXP_OFS       9'h002
`define SST_BYTE_LAST         3'h7

`endif

/* shared/sst_pkg.sv */
package sst_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SST_IDLE  = 2'b00,
        SST_LOAD  = 2'b01,
        SST_SHIFT = 2'b10
    } sst_fsm_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sst_bus_type;

    typedef struct packed {
        logic [8:0] cnt;
        logic       tick;
    } sst_div_type;

    typedef struct packed {
        sst_fsm_type fsm;
        logic        run;
        logic        abort;
        logic [1:0]  mode;
        logic [2:0]  sck_sel;
        logic        idle_run;
        logic        baud_zero;
        logic [7:0]  tx_buf;
        logic        tx_full;
        logic [7:0]  rx_buf;
        logic        rx_full;
        logic [7:0]  shreg;
        logic [2:0]  cnt;
        logic        active;
        logic        shift_active_flag;
        logic        dummy;
        logic        sck_out;
        logic        sck_oe_n;
        logic        so;
        logic        irq;
        logic [31:0] rdata;
        logic        sck1;
        logic        sck2;
        logic        sck3;
        logic        si1;
        logic        si2;
    } sst_state_type;

endpackage

/* hw/sst_clkgen.sv */
`timescale 1ns/1ps
`include "sst_consts.svh"

module sst_clkgen
    import sst_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Control
    input  wire logic       i_run,
    input  wire logic [2:0] i_sel,
    // Half period tick
    output logic            o_tick
);

    // ------------------------------------------------------------
    // Half period limit
    // ------------------------------------------------------------
    function automatic logic [8:0] half_limit(input logic [2:0] sel);
        logic [8:0] ex;
        ex = {6'h00, sel} + `SST_DIV_EXP_OFS;
        half_limit = (9'h001 << ex) - 9'h001;
    endfunction

    sst_div_type st;
    sst_div_type next_st;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Stopping the count restarts it, so a resumed clock gets a
    // full first half period.
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!i_run) begin
            next_st.cnt = 9'h000;
        end else if (st.cnt >= half_limit(i_sel)) begin
            next_st.cnt = 9'h000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 9'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;

endmodule // sst_clkgen

/* hw/sst_shift_tx.sv */
// Functional notes
// - Status bit 3 shows transfer active.
// - Status bit 2 shows shift in progress.
// - Baud bit 6 keeps unit running when idle.
// - Select 111 uses external serial clock.
// - Seven internal clock rates driven out.
// - Serial clock output high at transfer start.
// - Internal clock waits until software services buffers.
// - Output changes falling edge, sample rising edge.
// - Mode picks transmit, receive or both.
// - Start sends buffered byte LSB first.
// - Buffer to shift move raises interrupt, except in receiving modes.
// - Internal transmit stalls until buffer written.
// - Last previous bit held until first fall.
// - Run cleared finishes byte, then ends.
// - Forced abort stops at once, clears active.
// - External clock, run still set: dummy byte.
// - Data buffer write and read storage separate.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "sst_consts.svh"

module sst_shift_tx
    import sst_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Register bus
    input  wire sst_bus_type i_bus,
    output logic [31:0]      o_rdata,
    // System
    input  wire logic        i_idle,
    // Serial pins
    input  wire logic        i_sck,
    output logic             o_sck,
    output logic             o_sck_oe_n,
    output logic             o_so,
    input  wire logic        i_si,
    // Event
    output logic             o_serial_irq
);

    sst_state_type st;
    sst_state_type next_st;

    logic tick;
    logic ext;
    logic freeze;
    logic fall;
    logic rise;
    logic tx_mode;
    logic rx_mode;
    logic div_run;
    logic can_load;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    // Outside clock select; also decides who drives the pin
    function automatic logic sel_is_ext(input logic [2:0] sel);
        sel_is_ext = (sel == `SST_SCK_EXT);
    endfunction

    // Reserved code 01 behaves as plain transmit
    function automatic logic mode_sends(input logic [1:0] mode);
        mode_sends = (mode != `SST_MODE_RX);
    endfunction

    function automatic logic mode_takes(input logic [1:0] mode);
        mode_takes = mode[1];
    endfunction

    // Control readback; bit 3 is a fixed one
    function automatic logic [31:0] ctrl_word(input sst_state_type s);
        ctrl_word = `SST_CTRL_ONES
            | {24'h000000, s.run, s.abort, s.mode, 1'b0, s.sck_sel};
    endfunction

    function automatic logic [31:0] status_word(input logic act,
                                                input logic shf);
        status_word = `SST_STATUS_ONES;
        status_word[`SST_BIT_ACTIVE] = act;
        status_word[`SST_BIT_SHIFT] = shf;
    endfunction

    // Bit 0 reads back as written; software must keep it zero
    function automatic logic [31:0] baud_word(input logic run_idle,
                                              input logic zero);
        baud_word = `SST_BAUD_ONES;
        baud_word[`SST_BIT_IDLE_RUN] = run_idle;
        baud_word[`SST_BIT_BAUD_ZERO] = zero;
    endfunction

    // ------------------------------------------------------------
    // Internal clock divider
    // ------------------------------------------------------------
    assign ext     = sel_is_ext(st.sck_sel);
    assign freeze  = i_idle & ~st.idle_run;
    assign div_run = (st.fsm == SST_SHIFT) & ~ext & ~freeze;

    sst_clkgen u_clkgen (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_run  (div_run),
        .i_sel  (st.sck_sel),
        .o_tick (tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.irq = 1'b0;
        next_st.rdata = 32'h00000000;

        // Pins pass two flops; third flop only for edge finding
        next_st.sck1 = i_sck;
        next_st.sck2 = st.sck1;
        next_st.sck3 = st.sck2;
        next_st.si1 = i_si;
        next_st.si2 = st.si1;

        tx_mode = mode_sends(st.mode);
        rx_mode = mode_takes(st.mode);

        if (ext) begin
            fall = st.sck3 & ~st.sck2 & ~freeze;
            rise = ~st.sck3 & st.sck2 & ~freeze;
        end else begin
            // A tick that meets idle is dropped, so the pin stays put
            fall = tick & st.sck_out & ~freeze;
            rise = tick & ~st.sck_out & ~freeze;
        end

        // Internal clock only starts once the buffers its mode uses are serviced
        can_load = (!tx_mode || st.tx_full)
                 && (ext || !rx_mode || !st.rx_full);

        // --------------------------------------------------------
        // Reads
        // --------------------------------------------------------
        if (i_bus.rd) begin
            case (i_bus.addr)
                `SST_OFS_CONTROL_ONE: begin
                    next_st.rdata = ctrl_word(st);
                end
                `SST_OFS_DATA_BUFFER: begin
                    next_st.rdata = {24'h000000, st.rx_buf};
                    next_st.rx_full = 1'b0;
                end
                `SST_OFS_SERIAL_STATUS: begin
                    next_st.rdata = status_word(st.active, st.shift_active_flag);
                end
                `SST_OFS_BAUD_IDLE: begin
                    next_st.rdata = baud_word(st.idle_run, st.baud_zero);
                end
                default: begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end

        // --------------------------------------------------------
        // Transfer sequencer
        // --------------------------------------------------------
        case (st.fsm)
            SST_IDLE: begin
                next_st.sck_out = 1'b1;
            end
            SST_LOAD: begin
                next_st.sck_out = 1'b1;
                if (!st.run) begin
                    next_st.fsm = SST_IDLE;
                    next_st.active = 1'b0;
                end else if (can_load) begin
                    next_st.shreg = tx_mode ? st.tx_buf : 8'h00;
                    next_st.cnt = 3'h0;
                    next_st.shift_active_flag = 1'b1;
                    next_st.fsm = SST_SHIFT;
                    if (tx_mode) begin
                        next_st.tx_full = 1'b0;
                        next_st.irq = ~rx_mode;
                    end
                end else if (ext && fall) begin
                    // Software missed the deadline; shift out filler
                    next_st.shreg = `SST_DUMMY_BYTE;
                    next_st.so = 1'b1;
                    next_st.dummy = 1'b1;
                    next_st.cnt = 3'h0;
                    next_st.shift_active_flag = 1'b1;
                    next_st.fsm = SST_SHIFT;
                end
            end
            SST_SHIFT: begin
                if (!ext && tick && !freeze) begin
                    next_st.sck_out = ~st.sck_out;
                end
                if (fall && tx_mode) begin
                    next_st.so = st.shreg[0];
                end
                if (rise) begin
                    next_st.shreg = {st.si2, st.shreg[7:1]};
                    next_st.cnt = st.cnt + 3'h1;
                    if (st.cnt == `SST_BYTE_LAST) begin
                        next_st.shift_active_flag = 1'b0;
                        if (rx_mode) begin
                            next_st.rx_buf = {st.si2, st.shreg[7:1]};
                            next_st.rx_full = 1'b1;
                            next_st.irq = 1'b1;
                        end
                        if (!st.run || st.dummy) begin
                            next_st.fsm = SST_IDLE;
                            next_st.active = 1'b0;
                            next_st.dummy = 1'b0;
                        end else begin
                            next_st.fsm = SST_LOAD;
                        end
                    end
                end
            end
            default: begin
                next_st.fsm = SST_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // Writes, after the sequencer so a set wins over a clear
        // --------------------------------------------------------
        if (i_bus.wr) begin
            case (i_bus.addr)
                `SST_OFS_CONTROL_ONE: begin
                    next_st.run = i_bus.wdata[`SST_BIT_RUN];
                    next_st.abort = i_bus.wdata[`SST_BIT_ABORT];
                    next_st.mode =
                        i_bus.wdata[`SST_BIT_MODE_HI:`SST_BIT_MODE_LO];
                    next_st.sck_sel =
                        i_bus.wdata[`SST_BIT_SCK_HI:`SST_BIT_SCK_LO];
                    if (i_bus.wdata[`SST_BIT_ABORT]) begin
                        next_st.fsm = SST_IDLE;
                        next_st.active = 1'b0;
                        next_st.shift_active_flag = 1'b0;
                        next_st.dummy = 1'b0;
                        next_st.sck_out = 1'b1;
                    end else if (i_bus.wdata[`SST_BIT_RUN]
                                 && st.fsm == SST_IDLE) begin
                        next_st.fsm = SST_LOAD;
                        next_st.active = 1'b1;
                        next_st.sck_out = 1'b1;
                    end
                end
                `SST_OFS_DATA_BUFFER: begin
                    next_st.tx_buf = i_bus.wdata[7:0];
                    next_st.tx_full = 1'b1;
                end
                `SST_OFS_BAUD_IDLE: begin
                    next_st.idle_run = i_bus.wdata[`SST_BIT_IDLE_RUN];
                    // Stored as written; software keeps it zero
                    next_st.baud_zero = i_bus.wdata[`SST_BIT_BAUD_ZERO];
                end
                default: begin
                    next_st.run = st.run;
                end
            endcase
        end

        // External clock input leaves the pin undriven
        next_st.sck_oe_n = sel_is_ext(next_st.sck_sel);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
            st.fsm <= SST_IDLE;
            st.mode <= `SST_RST_MODE;
            st.sck_sel <= `SST_RST_SCK;
            st.sck_out <= 1'b1;
            st.sck1 <= 1'b1;
            st.sck2 <= 1'b1;
            st.sck3 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata      = st.rdata;
    assign o_sck        = st.sck_out;
    assign o_sck_oe_n   = st.sck_oe_n;
    assign o_so         = st.so;
    assign o_serial_irq = st.irq;

endmodule // sst_shift_tx

/* verification/sst_shift_tx_asserts.sv */
`timescale 1ns/1ps
`include "sst_consts.svh"

module sst_shift_tx_asserts
    import sst_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Register bus
    input  wire sst_bus_type i_bus,
    input  wire logic [31:0] o_rdata,
    // System
    input  wire logic        i_idle,
    // Serial pins
    input  wire logic        i_sck,
    input  wire logic        o_sck,
    input  wire logic        o_sck_oe_n,
    input  wire logic        o_so,
    input  wire logic        i_si,
    // Event
    input  wire logic        o_serial_irq
);
    // --------
    // Decoded accesses
    // --------
    logic wr_ctrl;
    logic ab_wr;
    logic go_wr;
    logic idle_run;

    assign wr_ctrl = i_bus.wr && i_bus.addr == `SST_OFS_CONTROL_ONE;
    assign ab_wr   = wr_ctrl && i_bus.wdata[`SST_BIT_ABORT];
    assign go_wr   = wr_ctrl && i_bus.wdata[`SST_BIT_RUN] && !ab_wr;

    // Mirror of the idle bit, so frozen edges can be told apart
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            idle_run <= 1'b0;
        end else if (i_bus.wr && i_bus.addr == `SST_OFS_BAUD_IDLE) begin
            idle_run <= i_bus.wdata[`SST_BIT_IDLE_RUN];
        end
    end

    // --------
    // Properties
    // --------
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_status_fixed: assert property (
        i_bus.rd && i_bus.addr == `SST_OFS_SERIAL_STATUS |=>
        (o_rdata & 32'hFFFFFFF3) == 32'h000000F3)
        else $error("status fixed bits wrong");
    a_baud_fixed: assert property (
        i_bus.rd && i_bus.addr == `SST_OFS_BAUD_IDLE |=>
        (o_rdata & 32'hFFFFFFBE) == 32'h000000BE)
        else $error("baud fixed bits wrong");
    a_rdata_quiet: assert property (
        !$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_so_on_fall: assert property (
        !o_sck_oe_n && $changed(o_so) |-> $fell(o_sck))
        else $error("data out moved off a falling edge");
    a_start_high: assert property (
        go_wr |=> o_sck [*3])
        else $error("clock not high at start");
    a_abort_stop: assert property (
        ab_wr |=> o_sck [*2])
        else $error("abort left clock running");
    a_irq_pulse: assert property (
        o_serial_irq |-> o_sck ##1 !o_serial_irq)
        else $error("interrupt not a pulse between edges");
    a_ext_oe: assert property (
        wr_ctrl && i_bus.wdata[2:0] == `SST_SCK_EXT |-> ##2 o_sck_oe_n)
        else $error("clock pin driven with outside clock");
    a_int_oe: assert property (
        wr_ctrl && i_bus.wdata[2:0] != `SST_SCK_EXT |-> ##2 !o_sck_oe_n)
        else $error("clock pin not driven with inside clock");
    a_idle_freeze: assert property (
        i_idle && !idle_run |=> $stable(o_sck))
        else $error("clock moved while stopped in idle");

    c_irq:   cover property (o_serial_irq);
    c_abort: cover property (ab_wr);
    c_ext:   cover property (o_sck_oe_n);
    c_idle:  cover property (i_idle && !idle_run);
endmodule // sst_shift_tx_asserts

bind sst_shift_tx sst_shift_tx_asserts i_sst_shift_tx_asserts (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_idle(i_idle), .i_sck(i_sck), .o_sck(o_sck),
    .o_sck_oe_n(o_sck_oe_n), .o_so(o_so), .i_si(i_si),
    .o_serial_irq(o_serial_irq));

/* verification/sst_peer.sv */
`timescale 1ns/1ps

module sst_peer #(
    parameter logic [7:0] TX_BYTE = 8'hC3
)
(
    // Control
    input  wire logic i_clr,
    input  wire logic i_ext_run,
    // Serial pins
    input  wire logic i_sck,
    input  wire logic i_so,
    output logic      o_sck,
    output logic      o_si,
    // Observed traffic
    output int        o_bits,
    output logic [7:0] o_byte
);
    logic [7:0] sh;
    int         idx;

    initial begin
        o_sck  = 1'b1;
        o_si   = 1'b0;
        o_bits = 0;
        o_byte = 8'h00;
        idx    = 0;
    end

    // Clock only inside frames, odd phase to the system clock
    always @(posedge i_ext_run) begin
        #33;
        while (i_ext_run) begin
            #400;
            if (i_ext_run) o_sck = 1'b0;
            #400 o_sck = 1'b1;
        end
    end

    always @(posedge i_clr) begin
        o_bits = 0;
        idx    = 0;
    end

    always @(negedge i_sck) begin
        o_si = TX_BYTE[idx];
        idx  = (idx + 1) % 8;
    end

    always @(posedge i_sck) begin
        sh = {i_so, sh[7:1]};
        o_bits++;
        if (o_bits % 8 == 0) o_byte = sh;
    end
endmodule // sst_peer

/* verification/sst_shift_tx_tb.sv */
`timescale 1ns/1ps
`include "sst_consts.svh"

`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("wrong value %s exp %0h got %0h", nm, e, g); \
        end \
    end

module sst_shift_tx_tb
    import sst_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } sst_row_type;

    logic        i_clk   = 1'b0;
    logic        i_rst   = 1'b1;
    sst_bus_type bus     = '0;
    logic        idle    = 1'b0;
    logic        clr     = 1'b0;
    logic        ext_run = 1'b0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic        d_sck;
    logic        oe_n;
    logic        so;
    logic        si;
    logic        irq;
    logic        ext_sck;
    logic        pin;
    logic [7:0]  p_byte;
    int          bits;
    int          bad_count    = 0;
    int          total_checks = 0;
    int          irq_n        = 0;
    int          n;
    int          k;

    sst_row_type rows [11] = '{
        '{1'b0, 8'h08, 32'h00, 32'hF3},
        '{1'b0, 8'h0C, 32'h00, 32'hBE},
        '{1'b0, 8'h00, 32'h00, 32'h08},
        '{1'b1, 8'h0C, 32'h40, 32'hFE},
        '{1'b1, 8'h0C, 32'h00, 32'hBE},
        '{1'b1, 8'h08, 32'hFF, 32'hF3},
        '{1'b1, 8'h10, 32'hFF, 32'h00},
        '{1'b1, 8'h04, 32'hA5, 32'h00},
        '{1'b1, 8'h00, 32'h40, 32'h48},
        '{1'b1, 8'h00, 32'h47, 32'h4F},
        '{1'b1, 8'h00, 32'h40, 32'h48}
    };

    // Pin level from whoever drives it
    assign pin = oe_n ? ext_sck : d_sck;

    always #50 i_clk = ~i_clk;

    always @(posedge i_clk) if (irq === 1'b1) irq_n++;

    sst_shift_tx i_sst_shift_tx (
        .i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
        .i_idle(idle), .i_sck(pin), .o_sck(d_sck), .o_sck_oe_n(oe_n),
        .o_so(so), .i_si(si), .o_serial_irq(irq));

    sst_peer i_sst_peer (
        .i_clr(clr), .i_ext_run(ext_run), .i_sck(pin), .i_so(so),
        .o_sck(ext_sck), .o_si(si), .o_bits(bits), .o_byte(p_byte));

    // --------
    // Bus and helper tasks
    // --------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        bus <= '0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge i_clk);
    endtask

    task automatic fresh();
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
    endtask

    task automatic wait_bits(input int cnt);
        for (k = 0; k < 9000 && bits < cnt; k++) @(posedge i_clk);
        `CHK("bit count", cnt, bits);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Generous bound, the whole run is a few thousand cycles
    initial begin
        #2000000;
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, got);
            `CHK("register", rows[i].e, got);
        end
        // Transmit, stall, resume, stop after byte
        fresh();
        wr(8'h04, 32'hA5);
        wr(8'h00, 32'h80);
        rd(8'h08, got);
        `CHK("start flag", 1'b1, got[3]);
        wait_bits(8);
        `CHK("first byte", 8'hA5, p_byte);
        repeat (40) @(posedge i_clk);
        rd(8'h08, got);
        `CHK("stall status", 32'hFB, got);
        `CHK("stall clock", 1'b1, d_sck);
        `CHK("load irq", 1, irq_n);
        wr(8'h04, 32'h3C);
        #1 `CHK("held bit", 1'b1, so);
        repeat (8) @(posedge i_clk);
        wr(8'h00, 32'h00);
        wait_bits(16);
        `CHK("last byte", 8'h3C, p_byte);
        repeat (10) @(posedge i_clk);
        rd(8'h08, got);
        `CHK("end status", 32'hF3, got);
        // Idle freeze, then abort mid byte
        fresh();
        wr(8'h04, 32'h0F);
        wr(8'h00, 32'h80);
        repeat (12) @(posedge i_clk);
        rd(8'h08, got);
        `CHK("shift status", 32'hFF, got);
        idle <= 1'b1;
        repeat (2) @(posedge i_clk);
        n = bits;
        repeat (30) @(posedge i_clk);
        `CHK("idle freeze", n, bits);
        idle <= 1'b0;
        wr(8'h00, 32'h40);
        rd(8'h08, got);
        `CHK("abort status", 32'hF3, got);
        // Both directions, internal clock
        wr(8'h00, 32'h60);
        fresh();
        wr(8'h04, 32'h96);
        wr(8'h00, 32'hA0);
        wait_bits(8);
        `CHK("duplex out", 8'h96, p_byte);
        repeat (8) @(posedge i_clk);
        rd(8'h04, got);
        `CHK("duplex in", 32'hC3, got);
        `CHK("irq count", 4, irq_n);
        wr(8'h00, 32'h60);
        // Each inside rate, low half period
        for (int s = 0; s < 7; s++) begin
            wr(8'h00, 32'h40 | s);
            wr(8'h04, 32'h55);
            wr(8'h00, 32'h80 | s);
            n = 0;
            for (k = 0; k < 600 && d_sck !== 1'b0; k++) @(posedge i_clk);
            while (n < 600 && d_sck === 1'b0) begin
                n++;
                @(posedge i_clk);
            end
            `CHK("half period", 1 << (s + 2), n);
        end
        wr(8'h00, 32'h46);
        // Outside clock, run left set gives a filler byte
        wr(8'h00, 32'h47);
        fresh();
        wr(8'h04, 32'h5A);
        wr(8'h00, 32'h87);
        #1 `CHK("pin released", 1'b1, oe_n);
        @(posedge i_clk);
        ext_run <= 1'b1;
        wait_bits(8);
        `CHK("ext byte", 8'h5A, p_byte);
        wait_bits(16);
        ext_run <= 1'b0;
        `CHK("dummy byte", `SST_DUMMY_BYTE, p_byte);
        repeat (30) @(posedge i_clk);
        rd(8'h08, got);
        `CHK("dummy end", 32'hF3, got);
        // Idle with run enable keeps shifting, then reset mid byte
        wr(8'h0C, 32'h40);
        wr(8'h00, 32'h40);
        fresh();
        wr(8'h04, 32'hFF);
        idle <= 1'b1;
        wr(8'h00, 32'h80);
        wait_bits(3);
        repeat (16) @(posedge i_clk);
        `CHK("idle run", 5, bits);
        idle <= 1'b0;
        i_rst <= 1'b1;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        `CHK("reset pins", 4'h2, {so, irq, d_sck, oe_n});
        rd(8'h0C, got);
        `CHK("reset baud", 32'hBE, got);
        rd(8'h08, got);
        `CHK("reset status", 32'hF3, got);
        complete_run();
    end
endmodule // sst_shift_tx_tb
